// ---- verilog/ifd_core.sv ----
// instruction decoder, sequencer, core store and console registers on ahb-lite
// Function
// - instruction word is fifteen bits, 14 down to 0
// - codes 00-05 and 17 use first format
// - codes 06-16 use second format groups
// - function code is bits 14 to 11
// - second format selector is bits 10, 09
// - bit 10 chooses address or immediate operand
// - bit 09 adds index to operand field
// - operand field is bits 08 to 00
// - code 14 selects four arithmetic jumps
// - index register lives at core address zero
// - memory and program address are nine bits
// - program control register is six bits
// - core traffic passes exchange register, except the index read and stores, which go direct
// - fetch ascending addresses except after jumps
// - fetched word goes exchange, then control register
// - code 02 indirect step reads into q
// - repeat read advances memory and program address
// - code 17 step writes q to address, or a when bit 10 is set
// - repeat store advances both addresses by one
// - repeat lamp follows repeat switch
`timescale 1ns/1ps
module ifd_core #(
  parameter int DEPTH = ifd_pkg::MEM_DEPTH
) (
  input wire logic hclk, // bus clock, 10 mhz
  input wire logic hresetn, // async reset, active low
  input wire logic hsel, // slave select
  input wire logic [31:0] haddr, // byte address
  input wire logic [1:0] htrans, // transfer type
  input wire logic hwrite, // write strobe
  input wire logic [2:0] hsize, // transfer size
  input wire logic hready, // bus ready in
  input wire logic [31:0] hwdata, // write data
  output logic [31:0] hrdata, // read data
  output logic hreadyout, // slave ready
  output logic hresp, // always okay
  output logic repeat_lamp, // red repeat indicator
  output logic halted // sequencer stopped
);
  ifd_pkg::ifd_state_t state_reg;
  logic [14:0] mem [DEPTH];
  logic [5:0] u_reg;
  logic [8:0] s_reg, p_reg;
  logic [14:0] z_reg, q_reg, a_reg;
  logic [4:0] ctrl_reg;
  logic d_flag_reg;
  logic wr_pend_reg, rd_wait_reg;
  logic [7:0] addr_reg;
  logic [31:0] hrdata_reg;
  logic clear_pulse, d_pulse, step_pulse, go;
  logic bus_wr, accept;
  logic [3:0] fn;
  logic [1:0] sel;
  logic src_ind, idx_mod, second_format;
  logic [8:0] opnd;
  logic is_enter_q, is_enter_a, is_store_q, is_store_a, is_jump, is_stop, jump_taken;
  logic [14:0] operand;
  logic [31:0] rd_mux;

  // y portion of the word sits in s after translation
  ifd_fields u_fields (
    .instr({u_reg, s_reg}),
    .a_zero(a_reg == 15'h0000),
    .a_neg(a_reg[14]),
    .q_neg(q_reg[14]),
    .fn(fn),
    .sel(sel),
    .src_ind(src_ind),
    .idx_mod(idx_mod),
    .opnd(opnd),
    .second_format(second_format),
    .is_enter_q(is_enter_q),
    .is_enter_a(is_enter_a),
    .is_store_q(is_store_q),
    .is_store_a(is_store_a),
    .is_jump(is_jump),
    .is_stop(is_stop),
    .jump_taken(jump_taken)
  );

  // ahb-lite slave: writes zero wait, reads one wait so data come from a flop
  assign accept = hsel && htrans[1] && hready;
  assign hreadyout = !rd_wait_reg;
  assign hresp = 1'b0;
  assign hrdata = hrdata_reg;
  assign bus_wr = wr_pend_reg;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_reg <= 1'b0;
      rd_wait_reg <= 1'b0;
      addr_reg <= 8'h00;
    end else begin
      wr_pend_reg <= accept && hwrite;
      rd_wait_reg <= accept && !hwrite;
      if (accept) begin
        addr_reg <= haddr[7:0];
      end
    end
  end

  always_comb begin
    case (addr_reg)
      ifd_pkg::OFS_CTRL: rd_mux = {27'h0000000, ctrl_reg};
      ifd_pkg::OFS_STAT: rd_mux = {26'h0000000, d_flag_reg, halted, repeat_lamp, 3'(state_reg)};
      ifd_pkg::OFS_U: rd_mux = {26'h0000000, u_reg};
      ifd_pkg::OFS_S: rd_mux = {23'h000000, s_reg};
      ifd_pkg::OFS_P: rd_mux = {23'h000000, p_reg};
      ifd_pkg::OFS_Q: rd_mux = {17'h00000, q_reg};
      ifd_pkg::OFS_A: rd_mux = {17'h00000, a_reg};
      ifd_pkg::OFS_DEC: rd_mux = {22'h000000, second_format, fn, sel, src_ind, idx_mod, jump_taken};
      default: rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_reg <= 32'h00000000;
    end else if (rd_wait_reg) begin
      hrdata_reg <= rd_mux;
    end
  end

  // console switches: clear, enable d and step are momentary, repeat and run lock
  assign clear_pulse = bus_wr && (addr_reg == ifd_pkg::OFS_CTRL) && hwdata[ifd_pkg::CTRL_CLEAR];
  assign d_pulse = bus_wr && (addr_reg == ifd_pkg::OFS_CTRL) && hwdata[ifd_pkg::CTRL_ENABLE_D];
  assign step_pulse = bus_wr && (addr_reg == ifd_pkg::OFS_CTRL) && hwdata[ifd_pkg::CTRL_STEP];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= 5'h00;
    end else if (bus_wr && addr_reg == ifd_pkg::OFS_CTRL) begin
      ctrl_reg <= {hwdata[ifd_pkg::CTRL_RUN], 1'b0, hwdata[ifd_pkg::CTRL_REPEAT], 2'h0};
    end
  end

  assign repeat_lamp = ctrl_reg[ifd_pkg::CTRL_REPEAT];
  assign halted = state_reg == ifd_pkg::ST_HALT;
  assign go = halted && (step_pulse || ctrl_reg[ifd_pkg::CTRL_RUN]) && !clear_pulse;

  // d sequence flag; enabling wins over the clear at the end of execution
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d_flag_reg <= 1'b0;
    end else if (d_pulse) begin
      d_flag_reg <= 1'b1;
    end else if (clear_pulse) begin
      d_flag_reg <= 1'b0;
    end else if (state_reg == ifd_pkg::ST_EXEC && !ctrl_reg[ifd_pkg::CTRL_REPEAT]) begin
      d_flag_reg <= 1'b0;
    end
  end

  // operand: exchange contents when indirect, otherwise the field itself
  assign operand = src_ind ? z_reg : {6'h00, s_reg};

  // sequencer and machine registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= ifd_pkg::ST_HALT;
      u_reg <= 6'h00;
      s_reg <= 9'h000;
      p_reg <= 9'h000;
      z_reg <= 15'h0000;
      q_reg <= 15'h0000;
      a_reg <= 15'h0000;
    end else if (clear_pulse) begin
      state_reg <= ifd_pkg::ST_HALT;
      u_reg <= 6'h00;
      s_reg <= 9'h000;
      p_reg <= 9'h000;
      z_reg <= 15'h0000;
      q_reg <= 15'h0000;
      a_reg <= 15'h0000;
    end else begin
      case (state_reg)
        ifd_pkg::ST_HALT: begin
          // console may only set registers while stopped
          if (bus_wr) begin
            case (addr_reg)
              ifd_pkg::OFS_U: u_reg <= hwdata[5:0];
              ifd_pkg::OFS_S: s_reg <= hwdata[8:0];
              ifd_pkg::OFS_P: p_reg <= hwdata[8:0];
              ifd_pkg::OFS_Q: q_reg <= hwdata[14:0];
              ifd_pkg::OFS_A: a_reg <= hwdata[14:0];
              default: ;
            endcase
          end
          if (go) begin
            state_reg <= d_flag_reg ? ifd_pkg::ST_OPER : ifd_pkg::ST_FETCH;
          end
        end
        ifd_pkg::ST_FETCH: begin
          z_reg <= mem[p_reg];
          p_reg <= 9'(p_reg + 9'h001);
          state_reg <= ifd_pkg::ST_XLATE;
        end
        ifd_pkg::ST_XLATE: begin
          u_reg <= z_reg[14:9];
          s_reg <= z_reg[8:0];
          state_reg <= ifd_pkg::ST_INDEX;
        end
        ifd_pkg::ST_INDEX: begin
          if (idx_mod) begin
            s_reg <= 9'(s_reg + mem[ifd_pkg::INDEX_ADDR][8:0]);
          end
          state_reg <= ifd_pkg::ST_OPER;
        end
        ifd_pkg::ST_OPER: begin
          // in the d sequence s was set by hand and is the operand address
          if (src_ind && !is_store_q && !is_store_a) begin
            z_reg <= mem[s_reg];
          end
          state_reg <= ifd_pkg::ST_EXEC;
        end
        ifd_pkg::ST_EXEC: begin
          if (is_enter_q) begin
            q_reg <= operand;
          end
          if (is_enter_a) begin
            a_reg <= operand;
          end
          if (is_store_q || is_store_a) begin
            z_reg <= is_store_q ? q_reg : a_reg;
          end
          if (d_flag_reg && ctrl_reg[ifd_pkg::CTRL_REPEAT]) begin
            s_reg <= 9'(s_reg + 9'h001);
            p_reg <= 9'(p_reg + 9'h001);
          end else if (is_jump || jump_taken) begin
            p_reg <= s_reg;
          end
          // auto run continues unless stopped; manual steps always halt
          if (!d_flag_reg && ctrl_reg[ifd_pkg::CTRL_RUN] && !is_stop) begin
            state_reg <= ifd_pkg::ST_FETCH;
          end else begin
            state_reg <= ifd_pkg::ST_HALT;
          end
        end
        default: state_reg <= ifd_pkg::ST_HALT;
      endcase
    end
  end

  // core store; contents survive master clear, like the real core
  always_ff @(posedge hclk) begin
    if (state_reg == ifd_pkg::ST_EXEC && !clear_pulse && (is_store_q || is_store_a)) begin
      mem[s_reg] <= is_store_q ? q_reg : a_reg;
    end
  end

  sequence s_fetch;
    state_reg == ifd_pkg::ST_FETCH ##1 state_reg == ifd_pkg::ST_XLATE;
  endsequence

  sequence s_step_d;
    go && d_flag_reg ##1 state_reg == ifd_pkg::ST_OPER;
  endsequence

  a_fetch_advance: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ifd_pkg::ST_FETCH && !clear_pulse |=> p_reg == 9'($past(p_reg) + 9'h001))
    else $error("program address did not advance on fetch");
  a_fetch_to_u: assert property (@(posedge hclk) disable iff (!hresetn)
    s_fetch and (!clear_pulse [*2]) |=> u_reg == $past(z_reg[14:9]))
    else $error("fetched word did not reach control register");
  a_index_add: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ifd_pkg::ST_INDEX && idx_mod && !clear_pulse
    |=> s_reg == 9'($past(s_reg) + $past(mem[0][8:0])))
    else $error("index from address zero not added");
  a_dseq_skip: assert property (@(posedge hclk) disable iff (!hresetn)
    s_step_d |-> state_reg != ifd_pkg::ST_FETCH ##1 state_reg == ifd_pkg::ST_EXEC)
    else $error("d sequence did not skip the fetch");
  a_read_q: assert property (@(posedge hclk) disable iff (!hresetn)
    go && d_flag_reg && is_enter_q && src_ind && !ctrl_reg[ifd_pkg::CTRL_REPEAT]
    |-> ##3 q_reg == $past(mem[s_reg], 3) && halted)
    else $error("manual read did not load q and halt");
  a_store_q: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ifd_pkg::ST_EXEC && is_store_q && !clear_pulse |=> mem[$past(s_reg)] == $past(q_reg))
    else $error("store did not write q to memory");
  a_repeat_adv: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ifd_pkg::ST_EXEC && d_flag_reg && ctrl_reg[ifd_pkg::CTRL_REPEAT] && !clear_pulse
    |=> s_reg == 9'($past(s_reg) + 9'h001) && p_reg == 9'($past(p_reg) + 9'h001) && d_flag_reg)
    else $error("repeat did not advance both addresses");
  a_arith_jump: assert property (@(posedge hclk) disable iff (!hresetn)
    state_reg == ifd_pkg::ST_EXEC && fn == ifd_pkg::FN_ARITH_JUMP && !d_flag_reg && !clear_pulse
    |=> p_reg == ($past(jump_taken) ? $past(s_reg) : $past(p_reg)))
    else $error("arithmetic jump went the wrong way");
  a_format_split: assert property (@(posedge hclk) disable iff (!hresetn)
    second_format == (u_reg[5:2] >= 4'h6 && u_reg[5:2] <= 4'he))
    else $error("format classification wrong");
  a_repeat_lamp: assert property (@(posedge hclk) disable iff (!hresetn)
    bus_wr && addr_reg == ifd_pkg::OFS_CTRL |=> repeat_lamp == $past(hwdata[ifd_pkg::CTRL_REPEAT]))
    else $error("repeat lamp does not follow switch");
endmodule

// ---- include/ifd_pkg.sv ----
// constants shared by the instruction format decoder and its console
package ifd_pkg;
  localparam int WORD_W = 15;
  localparam int ADDR_W = 9;
  localparam int CTRL_W = 6;
  localparam int MEM_DEPTH = 512;
  // instruction fields
  localparam int FN_HI = 14;
  localparam int FN_LO = 11;
  localparam int SEL_HI = 10;
  localparam int SEL_LO = 9;
  localparam int SRC_BIT = 10;
  localparam int IDX_BIT = 9;
  localparam int OPND_HI = 8;
  // function codes
  localparam logic [3:0] FN_ENTER_A = 4'h1;
  localparam logic [3:0] FN_ENTER_Q = 4'h2;
  localparam logic [3:0] FN_FIRST_LAST = 4'h5;
  localparam logic [3:0] FN_SECOND_FIRST = 4'h6;
  localparam logic [3:0] FN_SECOND_LAST = 4'he;
  localparam logic [3:0] FN_ARITH_JUMP = 4'hc;
  localparam logic [3:0] FN_JUMP_STOP = 4'hd;
  localparam logic [3:0] FN_STORE = 4'hf;
  localparam logic [1:0] SEL_UNCOND = 2'h0;
  localparam logic [1:0] SEL_STOP = 2'h2;
  localparam logic [1:0] SEL_A_NONZERO = 2'h0;
  localparam logic [1:0] SEL_A_ZERO = 2'h1;
  localparam logic [1:0] SEL_A_NEG = 2'h2;
  localparam logic [1:0] SEL_Q_NEG = 2'h3;
  localparam logic [ADDR_W-1:0] INDEX_ADDR = 9'h000;
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_U = 8'h08;
  localparam logic [7:0] OFS_S = 8'h0c;
  localparam logic [7:0] OFS_P = 8'h10;
  localparam logic [7:0] OFS_Q = 8'h14;
  localparam logic [7:0] OFS_A = 8'h18;
  localparam logic [7:0] OFS_DEC = 8'h1c;
  // control register bits
  localparam int CTRL_CLEAR = 0;
  localparam int CTRL_ENABLE_D = 1;
  localparam int CTRL_REPEAT = 2;
  localparam int CTRL_STEP = 3;
  localparam int CTRL_RUN = 4;
  typedef enum logic [2:0] {ST_HALT, ST_FETCH, ST_XLATE, ST_INDEX, ST_OPER, ST_EXEC} ifd_state_t;
endpackage

// ---- verilog/ifd_fields.sv ----
// field split and format classification of one instruction word
`timescale 1ns/1ps
module ifd_fields (
  input wire logic [14:0] instr, // instruction word
  input wire logic a_zero, // accumulator is zero
  input wire logic a_neg, // accumulator sign
  input wire logic q_neg, // auxiliary register sign
  output logic [3:0] fn, // function code
  output logic [1:0] sel, // group selector
  output logic src_ind, // operand is at address
  output logic idx_mod, // add index to operand
  output logic [8:0] opnd, // operand field
  output logic second_format, // group-select format
  output logic is_enter_q, // load q
  output logic is_enter_a, // load accumulator
  output logic is_store_q, // store q
  output logic is_store_a, // store accumulator
  output logic is_jump, // unconditional or stop
  output logic is_stop, // jump then stop
  output logic jump_taken // arithmetic jump condition met
);
  always_comb begin
    fn = instr[ifd_pkg::FN_HI:ifd_pkg::FN_LO];
    sel = instr[ifd_pkg::SEL_HI:ifd_pkg::SEL_LO];
    opnd = instr[ifd_pkg::OPND_HI:0];
    second_format = (fn >= ifd_pkg::FN_SECOND_FIRST) && (fn <= ifd_pkg::FN_SECOND_LAST);
    // designators only mean something in the first format
    src_ind = !second_format && instr[ifd_pkg::SRC_BIT];
    idx_mod = !second_format && instr[ifd_pkg::IDX_BIT];
    is_enter_q = fn == ifd_pkg::FN_ENTER_Q;
    is_enter_a = fn == ifd_pkg::FN_ENTER_A;
    is_store_q = (fn == ifd_pkg::FN_STORE) && !instr[ifd_pkg::SRC_BIT];
    is_store_a = (fn == ifd_pkg::FN_STORE) && instr[ifd_pkg::SRC_BIT];
    is_stop = (fn == ifd_pkg::FN_JUMP_STOP) && (sel == ifd_pkg::SEL_STOP);
    is_jump = is_stop || ((fn == ifd_pkg::FN_JUMP_STOP) && (sel == ifd_pkg::SEL_UNCOND));
    jump_taken = 1'b0;
    if (fn == ifd_pkg::FN_ARITH_JUMP) begin
      case (sel)
        ifd_pkg::SEL_A_NONZERO: jump_taken = !a_zero;
        ifd_pkg::SEL_A_ZERO: jump_taken = a_zero;
        ifd_pkg::SEL_A_NEG: jump_taken = a_neg;
        ifd_pkg::SEL_Q_NEG: jump_taken = q_neg;
        default: jump_taken = 1'b0;
      endcase
    end
  end
endmodule

// ---- tb/ifd_console.sv ----
// operator console model: ahb-lite master that loads registers and pulses steps
`timescale 1ns/1ps
module ifd_console (
  input wire logic hclk, // bus clock
  input wire logic hreadyout, // slave ready, also bus ready
  output logic hsel, // slave select
  output logic [31:0] haddr, // byte address
  output logic [1:0] htrans, // transfer type
  output logic hwrite, // write strobe
  output logic [2:0] hsize, // always one word
  output logic [31:0] hwdata // write data
);
  logic [31:0] exp_q[$];
  logic [31:0] mask_q[$];
  string name_q[$];
  initial begin
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // request held until ready is sampled high; an unbounded wait is cut by the bench timeout
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hwdata <= ~hwdata;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    if (w) hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m, input string nm);
    exp_q.push_back(e & m);
    mask_q.push_back(m);
    name_q.push_back(nm);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic dsetup(input logic [5:0] u, input logic [8:0] s, input logic rep);
    wr(ifd_pkg::OFS_CTRL, 32'h1);
    wr(ifd_pkg::OFS_CTRL, {29'h0, rep, 2'h2});
    wr(ifd_pkg::OFS_U, {26'h0, u});
    wr(ifd_pkg::OFS_S, {23'h0, s});
  endtask
  task automatic step(input logic rep);
    wr(ifd_pkg::OFS_CTRL, {28'h0, 1'b1, rep, 2'h0});
  endtask
endmodule

// ---- tb/ifd_core_bench.sv ----
// self-checking bench for the instruction decoder core
`timescale 1ns/1ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin fail_count++; $display("MISMATCH %s expected %h seen %h", nm, e, g); end end
module ifd_core_bench;
  logic hclk;
  logic hresetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic repeat_lamp;
  logic halted;
  logic rd_pend;
  int fail_count;
  int check_count;
  int cycles;
  logic [14:0] ins;
  logic [14:0] av;
  logic [14:0] qv;
  logic [14:0] vals [4];
  logic [8:0] idx;
  logic [8:0] base;
  logic sec;
  logic jc;
  logic [7:0] ofs [5];
  logic [31:0] wmask [5];

  ifd_core i_ifd_core (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .repeat_lamp(repeat_lamp), .halted(halted));
  ifd_console i_ifd_console (.hclk(hclk), .hreadyout(hreadyout), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  initial begin
    hclk = 1'b0;
    hresetn = 1'b0;
    rd_pend = 1'b0;
    fail_count = 0;
    check_count = 0;
    cycles = 0;
  end
  always #50 hclk = ~hclk;

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end

  // read results are matched in issue order against the console's notes
  always @(posedge hclk) begin
    logic [31:0] e;
    logic [31:0] m;
    string nm;
    if (rd_pend && hreadyout === 1'b1 && i_ifd_console.exp_q.size() > 0) begin
      e = i_ifd_console.exp_q.pop_front();
      m = i_ifd_console.mask_q.pop_front();
      nm = i_ifd_console.name_q.pop_front();
      `CHK(nm, e, hrdata & m)
      `CHK("response", 1'b0, hresp)
    end
    if (hreadyout === 1'b1) rd_pend = hsel & htrans[1] & ~hwrite;
  end

  task automatic run_step(input logic rep, input int exp_lows);
    int lows;
    int n;
    lows = 0;
    n = 0;
    i_ifd_console.step(rep);
    do begin
      @(posedge hclk);
      n++;
      if (halted !== 1'b1) lows++;
    end while ((halted !== 1'b1 || n < 2) && n < 64);
    if (exp_lows >= 0) `CHK("halted cycles", exp_lows, lows)
  endtask

  task automatic dstore(input logic [8:0] a, input logic [14:0] v);
    i_ifd_console.dsetup(6'h3c, a, 1'b0);
    i_ifd_console.wr(ifd_pkg::OFS_Q, {17'h0, v});
    run_step(1'b0, 2);
  endtask

  initial begin
    void'($urandom(33));
    ofs = '{ifd_pkg::OFS_U, ifd_pkg::OFS_S, ifd_pkg::OFS_P, ifd_pkg::OFS_Q, ifd_pkg::OFS_A};
    wmask = '{32'h3f, 32'h1ff, 32'h1ff, 32'h7fff, 32'h7fff};
    repeat (8) @(posedge hclk);
    `CHK("lamp at reset", 1'b0, repeat_lamp)
    hresetn <= 1'b1;
    i_ifd_console.rd(ifd_pkg::OFS_STAT, 32'h10, 32'hffffffff, "status");
    i_ifd_console.wr(8'h24, 32'hffffffff);
    i_ifd_console.rd(8'h24, 32'h0, 32'hffffffff, "unmapped");
    for (int i = 0; i < 5; i++) begin
      i_ifd_console.wr(ofs[i], 32'hffffffff);
      i_ifd_console.rd(ofs[i], wmask[i], 32'hffffffff, "width");
    end
    $display("test reset and widths done");
    for (int i = 0; i < 32; i++) begin
      ins = 15'($urandom());
      ins[14:11] = i[3:0];
      av = i[4] ? 15'h0 : 15'($urandom());
      qv = 15'($urandom());
      i_ifd_console.wr(ifd_pkg::OFS_A, {17'h0, av});
      i_ifd_console.wr(ifd_pkg::OFS_Q, {17'h0, qv});
      i_ifd_console.wr(ifd_pkg::OFS_U, {26'h0, ins[14:9]});
      i_ifd_console.wr(ifd_pkg::OFS_S, {23'h0, ins[8:0]});
      sec = ins[14:11] >= 4'h6 && ins[14:11] <= 4'he;
      case (ins[10:9])
        2'h0: jc = av != 15'h0;
        2'h1: jc = av == 15'h0;
        2'h2: jc = av[14];
        default: jc = qv[14];
      endcase
      i_ifd_console.rd(ifd_pkg::OFS_DEC, {22'h0, sec, ins[14:11], ins[10:9], ins[10], ins[9], jc},
        sec ? {31'h1fc, ins[14:11] == 4'hc} : 32'h3e6, "decode");
    end
    $display("test field decode done");
    qv = 15'($urandom());
    dstore(9'h101, qv);
    i_ifd_console.dsetup(6'h0a, 9'h101, 1'b0);
    run_step(1'b0, 2);
    i_ifd_console.rd(ifd_pkg::OFS_Q, {17'h0, qv}, 32'hffffffff, "manual read");
    i_ifd_console.rd(ifd_pkg::OFS_S, 32'h101, 32'hffffffff, "address kept");
    i_ifd_console.rd(ifd_pkg::OFS_STAT, 32'h10, 32'hffffffff, "d flag cleared");
    $display("test single read and write done");
    base = 9'h0a0;
    i_ifd_console.dsetup(6'h3c, base, 1'b1);
    i_ifd_console.wr(ifd_pkg::OFS_P, {23'h0, base + 9'h1});
    @(negedge hclk);
    `CHK("lamp up", 1'b1, repeat_lamp)
    for (int k = 0; k < 4; k++) begin
      vals[k] = 15'($urandom());
      i_ifd_console.wr(ifd_pkg::OFS_Q, {17'h0, vals[k]});
      run_step(1'b1, 2);
    end
    i_ifd_console.rd(ifd_pkg::OFS_S, {23'h0, base + 9'h4}, 32'hffffffff, "store s");
    i_ifd_console.rd(ifd_pkg::OFS_P, {23'h0, base + 9'h5}, 32'hffffffff, "store p");
    i_ifd_console.rd(ifd_pkg::OFS_STAT, 32'h38, 32'hffffffff, "repeat status");
    i_ifd_console.dsetup(6'h0a, base, 1'b1);
    i_ifd_console.wr(ifd_pkg::OFS_P, {23'h0, base + 9'h1});
    for (int k = 0; k < 4; k++) begin
      run_step(1'b1, 2);
      i_ifd_console.rd(ifd_pkg::OFS_Q, {17'h0, vals[k]}, 32'hffffffff, "repeat read");
    end
    i_ifd_console.rd(ifd_pkg::OFS_S, {23'h0, base + 9'h4}, 32'hffffffff, "read s");
    i_ifd_console.rd(ifd_pkg::OFS_P, {23'h0, base + 9'h5}, 32'hffffffff, "read p");
    i_ifd_console.wr(ifd_pkg::OFS_CTRL, 32'h1);
    @(negedge hclk);
    `CHK("lamp down", 1'b0, repeat_lamp)
    $display("test repeat mode done");
    idx = {5'h0, 4'($urandom())};
    qv = 15'($urandom());
    dstore(9'h000, {6'h0, idx});
    dstore(9'h030 + idx, qv);
    dstore(9'h080, {4'h2, 1'b1, 1'b1, 9'h030});
    dstore(9'h081, {4'hd, 2'h0, 9'h150});
    dstore(9'h150, {4'hc, 2'h1, 9'h0c0});
    i_ifd_console.wr(ifd_pkg::OFS_CTRL, 32'h1);
    i_ifd_console.wr(ifd_pkg::OFS_P, 32'h80);
    run_step(1'b0, 5);
    i_ifd_console.rd(ifd_pkg::OFS_Q, {17'h0, qv}, 32'hffffffff, "indexed operand");
    i_ifd_console.rd(ifd_pkg::OFS_S, {23'h0, 9'h030 + idx}, 32'hffffffff, "indexed address");
    i_ifd_console.rd(ifd_pkg::OFS_U, 32'h0b, 32'hffffffff, "control register");
    i_ifd_console.rd(ifd_pkg::OFS_P, 32'h81, 32'hffffffff, "next address");
    run_step(1'b0, 5);
    i_ifd_console.rd(ifd_pkg::OFS_P, 32'h150, 32'hffffffff, "jump target");
    run_step(1'b0, 5);
    i_ifd_console.rd(ifd_pkg::OFS_P, 32'hc0, 32'hffffffff, "arith jump");
    $display("test fetch, index and jump done");
    repeat (4) @(posedge hclk);
    print_verdict();
  end
endmodule
